/* dv/can_message_buffer_map_test.sv */
`timescale 1ns/1ns
`default_nettype none
module can_message_buffer_map_test
  import cmbm_pkg::*;
();
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  cmbm_rx_frame_s rx_head = '0;
  logic rx_head_valid = 1'b0;
  logic [7:0] rx_next_info = 8'h00;
  logic [7:0] rx_next_id1 = 8'h00;
  logic slow = 1'b0;
  logic [7:0] reg_rdata;
  logic rx_release, tx_req, tx_busy, tx_bit_adv, tx_bit, tx_bit_valid, tx_data_done;
  cmbm_tx_frame_s tx_frame;
  logic [63:0] bits;
  logic [6:0] nbits;
  int n_fail = 0;
  int n_compared = 0;
  // Free-running 20 MHz clock.
  always #25 clk_sys = ~clk_sys;
  cmbm_top cmbm_top_i (.clk_sys, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .rx_head, .rx_head_valid, .rx_next_info, .rx_next_id1, .rx_release,
    .tx_frame, .tx_req, .tx_busy, .tx_bit_adv, .tx_bit, .tx_bit_valid, .tx_data_done);
  cmbm_engine cmbm_engine_i (.clk_sys, .resetn, .slow, .tx_req, .tx_bit, .tx_bit_valid,
    .tx_bit_adv, .bits_q(bits), .nbits_q(nbits));
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(string nm, logic [63:0] seen, logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic results();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results
  // Bus cycles return just after the edge that took the strobe away.
  task automatic wr(logic [4:0] a, logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(logic [4:0] a, logic [7:0] e, string nm);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(nm, reg_rdata, e);
  endtask : rd
  // A lost completion ends the run rather than hanging it.
  task automatic wait_done();
    int i;
    for (i = 0; i < 2000 && tx_data_done !== 1'b1; i++) @(posedge clk_sys) #1;
    if (i == 2000) begin
      n_fail++;
      results();
    end
  endtask : wait_done
  ////////////////////////////////////////////////////////////////////////
  task automatic t_rx();
    @(posedge clk_sys);
    rx_head <= {1'b0, 1'b1, 4'h5, 11'h5a3, 18'h0, 64'h0807060504030201};
    rx_head_valid <= 1'b1;
    rx_next_info <= 8'h88;
    rx_next_id1 <= 8'h77;
    wr(5'h11, 8'hff);
    rd(5'h10, 8'h45, "info");
    rd(5'h11, 8'hb4, "std id1");
    rd(5'h12, 8'h70, "std id2");
    rd(5'h13, 8'h01, "std data1");
    rd(5'h1b, 8'h88, "next info");
    rd(5'h1c, 8'h77, "next id1");
    rd(5'h05, 8'h00, "unmapped");
    rd(5'h1f, 8'h01, "status idle");
    @(posedge clk_sys);
    rx_head <= {1'b1, 1'b1, 4'h8, 29'h0abcdef1, 64'h0807060504030201};
    rd(5'h10, 8'hc8, "ext info");
    rd(5'h15, 8'h01, "ext data1");
    rd(5'h1b, 8'h07, "ext data7");
    $display("done rx view");
  endtask : t_rx
  task automatic t_rel();
    wr(5'h1e, 8'h02);
    chk("release", rx_release, 1'b1);
    #50 chk("release once", rx_release, 1'b0);
    @(posedge clk_sys);
    rx_head_valid <= 1'b0;
    wr(5'h1e, 8'h02);
    chk("release empty", rx_release, 1'b0);
    $display("done release");
  endtask : t_rel
  task automatic t_std();
    wr(5'h10, 8'h02);
    wr(5'h11, 8'ha5);
    wr(5'h12, 8'hff);
    wr(5'h13, 8'h81);
    wr(5'h14, 8'h3c);
    wr(5'h1e, 8'h01);
    chk("std id", tx_frame.id[28:18], {8'ha5, 3'h7});
    chk("std fmt", tx_frame.ext, 1'b0);
    wait_done();
    chk("std count", nbits, 7'h10);
    chk("std bits", bits[15:0], 16'h813c);
    $display("done std send");
  endtask : t_std
  task automatic t_ext();
    slow <= 1'b1;
    wr(5'h10, 8'h8f);
    wr(5'h11, 8'h12);
    wr(5'h12, 8'h34);
    wr(5'h13, 8'h56);
    wr(5'h14, 8'h7f);
    for (int i = 0; i < 8; i++) wr(5'h15 + 5'(i), 8'hb0 + 8'(i));
    wr(5'h1e, 8'h01);
    chk("ext id a", tx_frame.id[28:21], 8'h12);
    chk("ext id b", tx_frame.id[20:13], 8'h34);
    chk("ext id c", tx_frame.id[12:5], 8'h56);
    chk("ext id d", tx_frame.id[4:0], 5'h0f);
    rd(5'h1f, 8'h02, "status busy");
    wait_done();
    chk("ext count", nbits, 7'h40);
    chk("ext bits", bits, 64'hb0b1b2b3b4b5b6b7);
    $display("done ext send");
  endtask : t_ext
  task automatic t_rtr();
    slow <= 1'b0;
    wr(5'h10, 8'h43);
    wr(5'h1e, 8'h01);
    chk("rtr flag", tx_frame.rtr, 1'b1);
    wait_done();
    chk("rtr count", nbits, 7'h00);
    $display("done remote send");
  endtask : t_rtr
  // Reset for five cycles, then the scenarios in turn.
  initial begin
    repeat (5) @(posedge clk_sys);
    resetn <= 1'b1;
    t_rx();
    t_rel();
    t_std();
    t_ext();
    t_rtr();
    results();
  end
endmodule : can_message_buffer_map_test
`default_nettype wire

/* dv/cmbm_chk_sva.sv */
`timescale 1ns/1ns
`default_nettype none
// Port checks for the message window; all in one clock domain.
module cmbm_chk
  import cmbm_pkg::*;
#(
  parameter int DEPTH = 13
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire cmbm_rx_frame_s rx_head,
  input wire logic rx_head_valid,
  input wire logic [7:0] rx_next_info,
  input wire logic rx_release,
  input wire cmbm_tx_frame_s tx_frame,
  input wire logic tx_req,
  input wire logic tx_busy,
  input wire logic tx_bit_adv,
  input wire logic tx_bit,
  input wire logic tx_bit_valid,
  input wire logic tx_data_done
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  logic rs;
  // Standard-format read strobe; the layout depends on the head frame.
  assign rs = reg_rd && !rx_head.ext;
  AST_INFO: assert property (reg_rd && reg_addr == 5'h10 |=>
    reg_rdata == {$past(rx_head.ext), $past(rx_head.rtr), 2'b00, $past(rx_head.dlc)})
    else $error("info byte wrong");
  AST_STD1: assert property (rs && reg_addr == 5'h11 |=>
    reg_rdata == $past(rx_head.id[28:21])) else $error("std id one wrong");
  AST_STD2: assert property (rs && reg_addr == 5'h12 |=>
    reg_rdata == {$past(rx_head.id[20:18]), $past(rx_head.rtr), 4'h0})
    else $error("std id two wrong");
  AST_NEXT: assert property (rs && reg_addr == 5'h1b |=>
    reg_rdata == $past(rx_next_info)) else $error("next info wrong");
  AST_LOW: assert property (reg_rd && reg_addr < 5'h10 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_REL: assert property (rx_release |->
    $past(reg_wr && reg_addr == 5'h1e && reg_wdata[1] && rx_head_valid))
    else $error("release without cause");
  AST_DONE: assert property (tx_data_done |-> !tx_busy && $past(tx_busy))
    else $error("done without busy");
  AST_NODATA: assert property (tx_req && (tx_frame.rtr || tx_frame.dlc == 4'h0)
    |=> tx_data_done) else $error("empty frame not done");
  AST_HOLD: assert property (tx_bit_valid && !tx_bit_adv |=>
    tx_bit_valid && $stable(tx_bit)) else $error("bit not held");
  C_DONE: cover property (tx_data_done);
  C_REL: cover property (rx_release);
  C_NEXT: cover property (rs && reg_addr == 5'h1b);
endmodule : cmbm_chk
////////////////////////////////////////////////////////////////////////
bind cmbm_top cmbm_chk #(.DEPTH(DEPTH)) cmbm_chk_i (.clk_sys, .resetn, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rx_head, .rx_head_valid, .rx_next_info,
  .rx_release, .tx_frame, .tx_req, .tx_busy, .tx_bit_adv, .tx_bit, .tx_bit_valid,
  .tx_data_done);
`default_nettype wire

/* dv/cmbm_engine.sv */
`timescale 1ns/1ns
`default_nettype none
// Protocol engine stand-in that consumes the data bit stream.
module cmbm_engine (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic slow,
  input wire logic tx_req,
  input wire logic tx_bit,
  input wire logic tx_bit_valid,
  output logic tx_bit_adv,
  output logic [63:0] bits_q,
  output logic [6:0] nbits_q
);
  logic go_q;
  // consume valid bits
  // Combinational so that no advance is ever shown while the bit is invalid.
  assign tx_bit_adv = tx_bit_valid && (go_q || !slow);
  // Bits are shifted in as taken; a new frame clears the record.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      go_q <= 1'b0;
      bits_q <= '0;
      nbits_q <= '0;
    end else begin
      go_q <= !go_q;
      if (tx_req) begin
        bits_q <= '0;
        nbits_q <= '0;
      end else if (tx_bit_adv) begin
        bits_q <= {bits_q[62:0], tx_bit};
        nbits_q <= nbits_q + 7'h01;
      end
    end
  end
endmodule : cmbm_engine
`default_nettype wire

/* inc/cmbm_pkg.sv */
`include "cmbm_regs.svh"
package cmbm_pkg;
  typedef enum logic [1:0] {CMBM_IDLE, CMBM_FETCH, CMBM_LOAD, CMBM_SHIFT} cmbm_stream_e;

  // Frame as it leaves the buffer towards the protocol engine.
  typedef struct packed {
    logic ext;
    logic rtr;
    logic [`CMBM_DLC_W-1:0] dlc;
    logic [`CMBM_ID_W-1:0] id;
  } cmbm_tx_frame_s;

  // Oldest frame of the receive queue; a standard id sits in bits 28-18.
  typedef struct packed {
    logic ext;
    logic rtr;
    logic [`CMBM_DLC_W-1:0] dlc;
    logic [`CMBM_ID_W-1:0] id;
    logic [`CMBM_DATA_BYTES-1:0][`CMBM_BYTE_W-1:0] data;
  } cmbm_rx_frame_s;

  // State of the top module apart from the transmit store.
  typedef struct packed {
    logic [`CMBM_BYTE_W-1:0] rdata;
    logic [`CMBM_BYTE_W-1:0] info;
    logic [3:0][`CMBM_BYTE_W-1:0] idb;
    cmbm_tx_frame_s txf;
    logic tx_req;
    logic rx_release;
    logic busy;
    logic done;
    cmbm_stream_e st;
    logic [`CMBM_IDX_W-1:0] idx;
    logic [`CMBM_IDX_W-1:0] count;
    logic [2:0] bitn;
    logic [`CMBM_BYTE_W-1:0] shift;
    logic bit_valid;
  } cmbm_state_s;
endpackage : cmbm_pkg

/* inc/cmbm_regs.svh */
// Overview of operation
// - Standard id low three bits from byte two
// - Extended id byte one gives bits 28-21
// - Extended id byte two gives bits 20-13
// - Extended id byte three gives bits 12-5
// - Extended id byte four 7-3 gives 4-0
// - Send data byte count from length code
// - Data sent MSB first, lowest address first
// - Data at 0x13-0x1A standard, 0x15-0x1C extended
// - Standard read 0x1B/0x1C shows next frame
// - Receive info byte: format, remote, zeros, length
// - Standard receive id byte one: top bits
// - Standard receive id byte two: low, remote
// - Transmit buffer write-only; reads show receive
// - Length above eight sends eight bytes
// - Info bit 7 extended, bit 6 remote
`ifndef CMBM_REGS_SVH
`define CMBM_REGS_SVH

// Widths of the register port and the frame fields.
`define CMBM_AW 5
`define CMBM_BYTE_W 8
`define CMBM_ID_W 29
`define CMBM_DLC_W 4
`define CMBM_IDX_W 4
`define CMBM_BUF_DEPTH 13
`define CMBM_MAX_BYTES 8
`define CMBM_DATA_BYTES 8

// Byte offsets on the register port.
`define CMBM_OFF_INFO 5'h10
`define CMBM_OFF_ID1 5'h11
`define CMBM_OFF_ID2 5'h12
`define CMBM_OFF_ID3 5'h13
`define CMBM_OFF_ID4 5'h14
`define CMBM_OFF_STD_DATA 5'h13
`define CMBM_OFF_EXT_DATA 5'h15
`define CMBM_OFF_STD_NEXT_INFO 5'h1b
`define CMBM_OFF_STD_NEXT_ID1 5'h1c
`define CMBM_OFF_LAST 5'h1c
`define CMBM_OFF_CMD 5'h1e
`define CMBM_OFF_STATUS 5'h1f

// Field positions.
`define CMBM_INFO_FMT_BIT 7
`define CMBM_INFO_RTR_BIT 6
`define CMBM_STD_ID2_RTR_BIT 4
`define CMBM_EXT_ID4_RTR_BIT 2
`define CMBM_CMD_TX_BIT 0
`define CMBM_CMD_RELEASE_BIT 1
`define CMBM_STAT_RX_VALID_BIT 0
`define CMBM_STAT_TX_BUSY_BIT 1

// Reset values and bit counts.
`define CMBM_BYTE_RST 8'h00
`define CMBM_BIT_TOP 3'h7
`define CMBM_BIT_LAST 3'h0

`endif

/* rtl/cmbm_mem.sv */
`timescale 1ns/1ns
`default_nettype none
// Small byte store with registered read data; contents are never reset.
module cmbm_mem #(
  parameter int DW = 8,
  parameter int DEPTH = 13,
  parameter int AW = 4
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic re,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [DEPTH];

  // Array write; no reset so the store maps onto plain RAM cells.
  always_ff @(posedge clk_sys) begin
    if (we && (int'(waddr) < DEPTH)) begin
      mem[waddr] <= wdata;
    end
  end

  // Read register, cleared by reset so the output is defined.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rdata <= '0;
    end else if (re && (int'(raddr) < DEPTH)) begin
      rdata <= mem[raddr];
    end
  end
endmodule : cmbm_mem
`default_nettype wire

/* rtl/cmbm_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "cmbm_regs.svh"
module cmbm_top
  import cmbm_pkg::*;
#(
  parameter int DEPTH = `CMBM_BUF_DEPTH
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [`CMBM_AW-1:0] reg_addr,
  input wire logic [`CMBM_BYTE_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`CMBM_BYTE_W-1:0] reg_rdata,
  input wire cmbm_rx_frame_s rx_head,
  input wire logic rx_head_valid,
  input wire logic [`CMBM_BYTE_W-1:0] rx_next_info,
  input wire logic [`CMBM_BYTE_W-1:0] rx_next_id1,
  output logic rx_release,
  output cmbm_tx_frame_s tx_frame,
  output logic tx_req,
  output logic tx_busy,
  input wire logic tx_bit_adv,
  output logic tx_bit,
  output logic tx_bit_valid,
  output logic tx_data_done
);
  cmbm_state_s s_q;
  cmbm_state_s s_d;
  logic mem_we;
  logic [`CMBM_IDX_W-1:0] mem_waddr;
  logic mem_re;
  logic [`CMBM_IDX_W-1:0] mem_raddr;
  logic [`CMBM_BYTE_W-1:0] mem_rdata;

  //////////////////////////////////////////////////////////////////////////////
  // Decoding helpers.

  // Number of data bytes to send for a given info byte.
  function automatic logic [`CMBM_IDX_W-1:0] data_count(input logic [`CMBM_BYTE_W-1:0] info);
    logic [`CMBM_DLC_W-1:0] dlc;
    dlc = info[`CMBM_DLC_W-1:0];
    if (dlc > `CMBM_DLC_W'(`CMBM_MAX_BYTES)) begin
      dlc = `CMBM_DLC_W'(`CMBM_MAX_BYTES);
    end
    data_count = info[`CMBM_INFO_RTR_BIT] ? '0 : `CMBM_IDX_W'(dlc);
  endfunction : data_count

  // Build the outgoing frame from the info byte and the four id bytes.
  function automatic cmbm_tx_frame_s build_tx(input logic [`CMBM_BYTE_W-1:0] info,
                                              input logic [3:0][`CMBM_BYTE_W-1:0] idb);
    cmbm_tx_frame_s f;
    f = '0;
    f.ext = info[`CMBM_INFO_FMT_BIT];
    f.rtr = info[`CMBM_INFO_RTR_BIT];
    f.dlc = info[`CMBM_DLC_W-1:0];
    if (f.ext) begin
      f.id[28:21] = idb[0];
      f.id[20:13] = idb[1];
      f.id[12:5] = idb[2];
      f.id[4:0] = idb[3][7:3];
    end else begin
      f.id[28:21] = idb[0];
      f.id[20:18] = idb[1][7:5];
    end
    build_tx = f;
  endfunction : build_tx

  // Byte seen by a read of the receive view at a buffer offset.
  function automatic logic [`CMBM_BYTE_W-1:0] rx_byte(input cmbm_rx_frame_s f,
                                                      input logic [`CMBM_AW-1:0] a,
                                                      input logic [`CMBM_BYTE_W-1:0] nxt_info,
                                                      input logic [`CMBM_BYTE_W-1:0] nxt_id1);
    logic [`CMBM_AW-1:0] base;
    logic [`CMBM_AW-1:0] rel;
    rx_byte = `CMBM_BYTE_RST;
    base = f.ext ? `CMBM_OFF_EXT_DATA : `CMBM_OFF_STD_DATA;
    rel = a - base;
    if (a == `CMBM_OFF_INFO) begin
      rx_byte = {f.ext, f.rtr, 2'b00, f.dlc};
    end else if (a == `CMBM_OFF_ID1) begin
      rx_byte = f.id[28:21];
    end else if (!f.ext && a == `CMBM_OFF_ID2) begin
      rx_byte = {f.id[20:18], f.rtr, 4'h0};
    end else if (f.ext && a == `CMBM_OFF_ID2) begin
      rx_byte = f.id[20:13];
    end else if (f.ext && a == `CMBM_OFF_ID3) begin
      rx_byte = f.id[12:5];
    end else if (f.ext && a == `CMBM_OFF_ID4) begin
      rx_byte = {f.id[4:0], f.rtr, 2'b00};
    end else if (!f.ext && a == `CMBM_OFF_STD_NEXT_INFO) begin
      rx_byte = nxt_info;
    end else if (!f.ext && a == `CMBM_OFF_STD_NEXT_ID1) begin
      rx_byte = nxt_id1;
    end else if (a >= base && a <= `CMBM_OFF_LAST) begin
      rx_byte = f.data[rel[2:0]];
    end
  endfunction : rx_byte

  //////////////////////////////////////////////////////////////////////////////
  // Transmit byte store.

  // Every buffer write is stored; the store feeds the data streamer only.
  always_comb begin
    mem_we = reg_wr && (reg_addr >= `CMBM_OFF_INFO) && (reg_addr <= `CMBM_OFF_LAST);
    mem_waddr = `CMBM_IDX_W'(reg_addr - `CMBM_OFF_INFO);
  end

  cmbm_mem #(
    .DW(`CMBM_BYTE_W),
    .DEPTH(DEPTH),
    .AW(`CMBM_IDX_W)
  ) u_txbuf (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(reg_wdata),
    .re(mem_re),
    .raddr(mem_raddr),
    .rdata(mem_rdata)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Next state.

  // Register port, command handling and the serial data streamer.
  always_comb begin
    logic [`CMBM_AW-1:0] base;
    s_d = s_q;
    base = s_q.txf.ext ? `CMBM_OFF_EXT_DATA : `CMBM_OFF_STD_DATA;
    s_d.rdata = `CMBM_BYTE_RST;
    s_d.tx_req = 1'b0;
    s_d.rx_release = 1'b0;
    s_d.done = 1'b0;
    mem_re = 1'b0;
    mem_raddr = `CMBM_IDX_W'(base - `CMBM_OFF_INFO) + s_q.idx;

    // Header bytes are shadowed so the frame can be built in one cycle.
    if (reg_wr && reg_addr == `CMBM_OFF_INFO) begin
      s_d.info = reg_wdata;
    end else if (reg_wr && reg_addr >= `CMBM_OFF_ID1 && reg_addr <= `CMBM_OFF_ID4) begin
      s_d.idb[reg_addr[1:0] - 2'd1] = reg_wdata;
    end

    if (reg_rd) begin
      if (reg_addr >= `CMBM_OFF_INFO && reg_addr <= `CMBM_OFF_LAST) begin
        s_d.rdata = rx_byte(rx_head, reg_addr, rx_next_info, rx_next_id1);
      end else if (reg_addr == `CMBM_OFF_STATUS) begin
        s_d.rdata[`CMBM_STAT_RX_VALID_BIT] = rx_head_valid;
        s_d.rdata[`CMBM_STAT_TX_BUSY_BIT] = s_q.busy;
      end
    end

    if (reg_wr && reg_addr == `CMBM_OFF_CMD && reg_wdata[`CMBM_CMD_RELEASE_BIT]) begin
      s_d.rx_release = rx_head_valid;
    end

    // A transmit command while a frame is still going out is dropped.
    if (reg_wr && reg_addr == `CMBM_OFF_CMD && reg_wdata[`CMBM_CMD_TX_BIT] && !s_q.busy) begin
      s_d.txf = build_tx(s_q.info, s_q.idb);
      s_d.count = data_count(s_q.info);
      s_d.tx_req = 1'b1;
      s_d.busy = 1'b1;
      s_d.idx = '0;
      s_d.st = CMBM_FETCH;
    end else begin
      unique case (s_q.st)
        CMBM_IDLE: begin
        end
        CMBM_FETCH: begin
          if (s_q.idx == s_q.count) begin
            s_d.done = 1'b1;
            s_d.busy = 1'b0;
            s_d.st = CMBM_IDLE;
          end else begin
            mem_re = 1'b1;
            s_d.st = CMBM_LOAD;
          end
        end
        CMBM_LOAD: begin
          s_d.shift = mem_rdata;
          s_d.bitn = `CMBM_BIT_TOP;
          s_d.bit_valid = 1'b1;
          s_d.st = CMBM_SHIFT;
        end
        CMBM_SHIFT: begin
          if (tx_bit_adv) begin
            if (s_q.bitn == `CMBM_BIT_LAST) begin
              s_d.bit_valid = 1'b0;
              s_d.idx = s_q.idx + `CMBM_IDX_W'(1);
              s_d.st = CMBM_FETCH;
            end else begin
              s_d.shift = {s_q.shift[`CMBM_BYTE_W-2:0], 1'b0};
              s_d.bitn = s_q.bitn - 3'd1;
            end
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register.

  // The whole state record is reset; bytes in the transmit store are left as they power up.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs come straight from the state register.
  assign reg_rdata = s_q.rdata;
  assign rx_release = s_q.rx_release;
  assign tx_frame = s_q.txf;
  assign tx_req = s_q.tx_req;
  assign tx_busy = s_q.busy;
  assign tx_bit = s_q.shift[`CMBM_BYTE_W-1];
  assign tx_bit_valid = s_q.bit_valid;
  assign tx_data_done = s_q.done;
endmodule : cmbm_top
`default_nettype wire
